// >>> dmacc_pkg.sv
package dmacc_pkg;
  localparam logic [7:0] DMACC_ADDR_CTL = 8'h00;
  localparam logic [7:0] DMACC_ADDR_SSIZ = 8'h04;
  localparam logic [7:0] DMACC_ADDR_PAT = 8'h08;
  localparam logic [7:0] DMACC_ADDR_STAT = 8'h0C;
  localparam int DMACC_IGN_LSB = 24;
  localparam int DMACC_BUSY_BIT = 15;
  localparam int DMACC_IGNEN_BIT = 13;
  localparam int DMACC_PATLEN_BIT = 11;
  localparam int DMACC_CHNS_BIT = 8;
  localparam int DMACC_EN_BIT = 7;
  localparam int DMACC_AED_BIT = 6;
  localparam int DMACC_CHN_BIT = 5;
  localparam int DMACC_STAT_ACT_BIT = 0;
  localparam int DMACC_STAT_PEND_BIT = 1;
  localparam int DMACC_STAT_HIT_BIT = 2;
  localparam int DMACC_STAT_CNT_LSB = 3;
  localparam logic [31:0] DMACC_CTL_WMASK = 32'hFF0029E0;
  localparam logic [31:0] DMACC_CTL_RST = 32'h00000000;
  localparam logic [15:0] DMACC_SSIZ_RST = 16'h0000;
  localparam logic [15:0] DMACC_PAT_RST = 16'h0000;
  localparam logic [2:0] DMACC_XFER_CYCLES = 3'h4;
  typedef enum logic [1:0] {
    DMACC_IDLE = 2'b00,
    DMACC_XFER = 2'b01,
    DMACC_DRAIN = 2'b10
  } dmacc_state_t;
  typedef struct packed {
    logic [7:0] ign;
    logic ign_en;
    logic pat_len;
    logic chn_sel;
    logic en;
    logic aed;
    logic chn;
  } dmacc_ctl_t;
endpackage : dmacc_pkg

// >>> dmacc_match.sv
`timescale 1ns/1ps
module dmacc_match
  import dmacc_pkg::*;
(
  // Pattern setup
  input wire logic [15:0] i_pat,
  input wire logic [7:0] i_ign,
  input wire logic i_ign_en,
  input wire logic i_pat_len,
  // Read data
  input wire logic [15:0] i_data,
  output logic o_hit
);
  logic [1:0] pos_ok;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pos
      assign pos_ok[g] = (i_data[8*g +: 8] == i_pat[8*g +: 8])
        || (i_ign_en && i_data[8*g +: 8] == i_ign);
    end
  endgenerate
  // Upper position only counts for two-byte patterns
  assign o_hit = pos_ok[0] && (pos_ok[1] || !i_pat_len);
endmodule : dmacc_match

// >>> dmacc_top.sv
`timescale 1ns/1ps
module dmacc_top
  import dmacc_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Channel events from same-clock logic
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_done_lower,
  input wire logic i_done_higher,
  // Data read stream
  input wire logic i_data_vld,
  input wire logic [15:0] i_data,
  // Status
  output logic o_busy,
  output logic o_xfer_active,
  output logic o_pat_hit,
  output logic o_done
);
  dmacc_ctl_t ctl_reg, ctl_next;
  logic [15:0] ssiz_reg, ssiz_next;
  logic [15:0] pat_reg, pat_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0] beat_reg, beat_next;
  dmacc_state_t st_reg, st_next;
  logic pend_reg, pend_next;
  logic [31:0] rdata_reg, rdata_next;
  logic busy_reg, busy_next;
  logic act_reg, act_next;
  logic hit_reg, hit_next;
  logic done_reg, done_next;
  logic hit_comb;
  logic chain_evt;
  logic wr_ctl;
  logic [31:0] ctl_word;
  logic [31:0] stat_word;
  logic evt_ok;
  logic start_ok;
  logic abort_ok;
  logic [15:0] step;
  logic [16:0] cnt_sum;
  logic size_end;

  dmacc_match u_match (
    .i_pat(pat_reg),
    .i_ign(ctl_reg.ign),
    .i_ign_en(ctl_reg.ign_en),
    .i_pat_len(ctl_reg.pat_len),
    .i_data(i_data),
    .o_hit(hit_comb)
  );

  assign wr_ctl = i_wr && (i_addr == DMACC_ADDR_CTL);
  // Chaining source chosen by direction bit, only when chaining allowed
  assign chain_evt = ctl_reg.chn
    && (ctl_reg.chn_sel ? i_done_lower : i_done_higher);

  // Start and abort share one gate: a disabled channel drops both unless allowed
  assign evt_ok = ctl_reg.en || ctl_reg.aed;
  assign start_ok = i_start && evt_ok;
  assign abort_ok = i_abort && evt_ok;

  // A two-byte pattern consumes a byte pair per beat
  assign step = ctl_reg.pat_len ? 16'h0002 : 16'h0001;
  // Carry kept so an all-ones size still ends in two-byte mode
  assign cnt_sum = {1'b0, cnt_reg} + {1'b0, step};
  assign size_end = cnt_sum >= {1'b0, ssiz_reg};

  always_comb
  begin
    ctl_word = 32'h00000000;
    ctl_word[DMACC_IGN_LSB +: 8] = ctl_reg.ign;
    ctl_word[DMACC_BUSY_BIT] = busy_reg;
    ctl_word[DMACC_IGNEN_BIT] = ctl_reg.ign_en;
    ctl_word[DMACC_PATLEN_BIT] = ctl_reg.pat_len;
    ctl_word[DMACC_CHNS_BIT] = ctl_reg.chn_sel;
    ctl_word[DMACC_EN_BIT] = ctl_reg.en;
    ctl_word[DMACC_AED_BIT] = ctl_reg.aed;
    ctl_word[DMACC_CHN_BIT] = ctl_reg.chn;
  end

  always_comb
  begin
    stat_word = 32'h00000000;
    stat_word[DMACC_STAT_ACT_BIT] = act_reg;
    stat_word[DMACC_STAT_PEND_BIT] = pend_reg;
    stat_word[DMACC_STAT_HIT_BIT] = hit_reg;
    stat_word[DMACC_STAT_CNT_LSB +: 16] = cnt_reg;
  end

  // Register file
  always_comb
  begin
    ctl_next = ctl_reg;
    ssiz_next = ssiz_reg;
    pat_next = pat_reg;
    // A software write of the control word wins over a same-cycle chain event
    if (wr_ctl)
    begin
      // Only implemented positions are stored
      ctl_next.ign = i_wdata[DMACC_IGN_LSB +: 8];
      ctl_next.ign_en = i_wdata[DMACC_IGNEN_BIT];
      ctl_next.pat_len = i_wdata[DMACC_PATLEN_BIT];
      ctl_next.chn_sel = i_wdata[DMACC_CHNS_BIT];
      ctl_next.en = i_wdata[DMACC_EN_BIT];
      ctl_next.aed = i_wdata[DMACC_AED_BIT];
      ctl_next.chn = i_wdata[DMACC_CHN_BIT];
    end
    else if (chain_evt)
    begin
      ctl_next.en = 1'b1;
    end
    if (i_wr && i_addr == DMACC_ADDR_SSIZ)
    begin
      ssiz_next = i_wdata[15:0];
    end
    if (i_wr && i_addr == DMACC_ADDR_PAT)
    begin
      pat_next = i_wdata[15:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctl_reg <= dmacc_ctl_t'(DMACC_CTL_RST[13:0]);
      ssiz_reg <= DMACC_SSIZ_RST;
      pat_reg <= DMACC_PAT_RST;
    end
    else if (i_ce)
    begin
      ctl_reg <= ctl_next;
      ssiz_reg <= ssiz_next;
      pat_reg <= pat_next;
    end
  end

  // Read port: a word stands for the one cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (i_rd)
    begin
      case (i_addr)
        DMACC_ADDR_CTL: rdata_next = ctl_word & (DMACC_CTL_WMASK
          | (32'h00000001 << DMACC_BUSY_BIT));
        DMACC_ADDR_SSIZ: rdata_next = {16'h0000, ssiz_reg};
        DMACC_ADDR_PAT: rdata_next = {16'h0000, pat_reg};
        DMACC_ADDR_STAT: rdata_next = stat_word;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_reg <= 32'h00000000;
    end
    else if (i_ce)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Channel engine
  always_comb
  begin
    st_next = st_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    beat_next = beat_reg;
    done_next = 1'b0;
    hit_next = hit_reg;
    if (start_ok)
    begin
      pend_next = 1'b1;
    end
    if (abort_ok)
    begin
      pend_next = 1'b0;
      st_next = DMACC_IDLE;
      cnt_next = 16'h0000;
    end
    else
    begin
      case (st_reg)
        DMACC_IDLE:
        begin
          // A zero size never launches, so an unprogrammed channel stays idle
          if (ctl_reg.en && pend_reg && ssiz_reg != 16'h0000)
          begin
            st_next = DMACC_XFER;
            // A start taken on the launch edge queues the next buffer
            pend_next = start_ok;
            cnt_next = 16'h0000;
            hit_next = 1'b0;
            beat_next = DMACC_XFER_CYCLES;
          end
        end
        DMACC_XFER:
        begin
          // A started beat is carried to its end unless aborted; a cleared enable then parks the buffer in DRAIN
          if (beat_reg != 3'h0)
          begin
            beat_next = beat_reg - 3'h1;
          end
          else if (i_data_vld)
          begin
            cnt_next = cnt_sum[15:0];
            if (hit_comb)
            begin
              hit_next = 1'b1;
            end
            if (hit_comb || size_end)
            begin
              st_next = DMACC_IDLE;
              done_next = 1'b1;
            end
            else if (!ctl_reg.en)
            begin
              st_next = DMACC_DRAIN;
            end
            else
            begin
              beat_next = DMACC_XFER_CYCLES;
            end
          end
        end
        DMACC_DRAIN:
        begin
          // Suspended mid-buffer; resumes when enabled again
          if (ctl_reg.en)
          begin
            st_next = DMACC_XFER;
            beat_next = DMACC_XFER_CYCLES;
          end
        end
        // Unused code falls back to idle
        default: st_next = DMACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_reg <= DMACC_IDLE;
      pend_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      beat_reg <= 3'h0;
      hit_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      st_reg <= st_next;
      pend_reg <= pend_next;
      cnt_reg <= cnt_next;
      beat_reg <= beat_next;
      hit_reg <= hit_next;
      done_reg <= done_next;
    end
  end

  // Flags track the sequencer's next state so they move with it
  always_comb
  begin
    act_next = (st_next == DMACC_XFER);
    // Busy covers enabled state and the XFER state only; a buffer suspended in DRAIN is not busy
    busy_next = ctl_next.en || act_next;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      act_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      act_reg <= act_next;
      busy_reg <= busy_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_busy = busy_reg;
  assign o_xfer_active = act_reg;
  assign o_pat_hit = hit_reg;
  assign o_done = done_reg;
endmodule : dmacc_top

// >>> dmacc_monitor.sv
`timescale 1ns/1ps
module dmacc_monitor
  import dmacc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_busy,
  input wire logic o_xfer_active,
  input wire logic o_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_rsv; i_rd && i_addr == DMACC_ADDR_CTL |=> (o_rdata & 32'h00FF561F) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_bsy; i_rd && i_addr == DMACC_ADDR_CTL |=> o_rdata[15] == $past(o_busy);
  endproperty
  a_bsy: assert property (p_bsy) else $error("busy bit wrong");
  property p_siz; i_rd && i_addr == DMACC_ADDR_SSIZ |=> o_rdata[31:16] == 16'h0000;
  endproperty
  a_siz: assert property (p_siz) else $error("size upper set");
  property p_map; i_rd && i_addr > DMACC_ADDR_STAT |=> o_rdata == 32'h0; endproperty
  a_map: assert property (p_map) else $error("unmapped nonzero");
  property p_act; o_xfer_active |-> o_busy; endproperty
  a_act: assert property (p_act) else $error("active not busy");
  property p_dn1; o_done |=> !o_done; endproperty
  a_dn1: assert property (p_dn1) else $error("done too long");
  property p_dn2; o_done |-> $past(o_xfer_active); endproperty
  a_dn2: assert property (p_dn2) else $error("done while idle");
  c_act: cover property ($rose(o_xfer_active));
  c_bsy: cover property ($fell(o_busy));
  c_dn: cover property (o_done);
endmodule : dmacc_monitor
bind dmacc_top dmacc_monitor u_mon (.*);

// >>> dmacc_far_model.sv
`timescale 1ns/1ps
module dmacc_far_model
(
  input wire logic i_core_clk,
  input wire logic i_act,
  input wire logic [3:0] i_gap,
  input wire logic [15:0] i_word,
  output logic o_vld,
  output logic [15:0] o_data
);
  logic [3:0] cnt = 4'h0;
  logic go;
  initial o_data = 16'h0000;
  initial o_vld = 1'b0;
  assign go = i_act && cnt == i_gap;
  // Idle data toggles so a stale word never passes for a match
  always @(posedge i_core_clk)
  begin
    o_vld <= go;
    o_data <= go ? i_word : ~o_data;
    cnt <= (i_act && !go) ? cnt + 4'h1 : 4'h0;
  end
endmodule : dmacc_far_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
  import dmacc_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, st = 1'b0, lo = 1'b0, hi = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [15:0] word = 16'h0000, data, s = 16'h0038;
  logic [3:0] gap = 4'h0;
  logic ab = 1'b0;
  logic vld, busy, act, hit, done;
  int miscompares = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  dmacc_top DUT (.i_core_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_start(st), .i_abort(ab),
    .i_done_lower(lo), .i_done_higher(hi), .i_data_vld(vld), .i_data(data),
    .o_busy(busy), .o_xfer_active(act), .o_pat_hit(hit), .o_done(done));
  dmacc_far_model FAR (.i_core_clk(clk), .i_act(act), .i_gap(gap), .i_word(word),
    .o_vld(vld), .o_data(data));
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask : rdc
  task automatic ev(input int w);
    @(posedge clk);
    st <= w == 0;
    lo <= w == 1;
    hi <= w == 2;
    ab <= w == 3;
    @(posedge clk);
    {st, lo, hi, ab} <= 4'h0;
  endtask : ev
  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (done !== 1'b1 && n < 300);
    chk(32'(n < 300), 32'h1);
  endtask : wait_done
  function automatic logic hit_f(input logic [15:0] d, input logic [7:0] g, input logic e, l);
    logic b0, b1;
    b0 = d[7:0] == 8'h5A || (e && d[7:0] == g);
    b1 = d[15:8] == 8'h3C || (e && d[15:8] == g);
    return l ? b0 && b1 : b0;
  endfunction : hit_f
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    #(25 * 60000);
    miscompares++;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdc(DMACC_ADDR_CTL, 32'h0);
    wr(DMACC_ADDR_CTL, 32'hFFFFFF7F);
    rdc(DMACC_ADDR_CTL, 32'hFF002960);
    wr(DMACC_ADDR_SSIZ, 32'hFFFFFFFF);
    rdc(DMACC_ADDR_SSIZ, 32'h0000FFFF);
    rdc(8'h10, 32'h0);
    $display("test registers done");
    wr(DMACC_ADDR_SSIZ, 32'h1);
    wr(DMACC_ADDR_CTL, 32'h0);
    ev(0);
    rdc(DMACC_ADDR_STAT, 32'h0);
    wr(DMACC_ADDR_CTL, 32'h80);
    @(posedge clk);
    #1 chk(act, 1'b0);
    wr(DMACC_ADDR_CTL, 32'h40);
    ev(0);
    rdc(DMACC_ADDR_STAT, 32'h2);
    wr(DMACC_ADDR_CTL, 32'h0);
    ev(3);
    rdc(DMACC_ADDR_STAT, 32'h2);
    wr(DMACC_ADDR_CTL, 32'h40);
    ev(3);
    rdc(DMACC_ADDR_STAT, 32'h0);
    ev(0);
    wr(DMACC_ADDR_CTL, 32'hC0);
    wait_done;
    $display("test events done");
    wr(DMACC_ADDR_PAT, 32'h00003C5A);
    for (int i = 0; i < 24; i++)
    begin
      s = lfsr(s);
      word <= {s[3] ? 8'h3C : s[15:8], s[5] ? 8'h5A : s[15:8]};
      gap <= {1'b0, s[7:5]};
      wr(DMACC_ADDR_SSIZ, s[1] ? 32'h2 : 32'h1);
      wr(DMACC_ADDR_CTL, {s[15:8], 10'h0, s[0], 1'b0, s[1], 11'h080});
      ev(0);
      wait_done;
      chk(hit, hit_f(word, s[15:8], s[0], s[1]));
    end
    $display("test pattern done");
    wr(DMACC_ADDR_SSIZ, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      wr(DMACC_ADDR_CTL, {23'h0, k[0], 2'h0, k[1], 5'h0});
      ev(k[2] ? 1 : 2);
      repeat (2) @(posedge clk);
      #1 chk(busy, k[1] && (k[0] == k[2]));
    end
    $display("test chain done");
    wr(DMACC_ADDR_SSIZ, 32'h40);
    word <= 16'h0000;
    wr(DMACC_ADDR_CTL, 32'h80);
    ev(0);
    @(posedge clk);
    #1 chk(act, 1'b1);
    wr(DMACC_ADDR_CTL, 32'h0);
    #1 chk(busy, 1'b1);
    for (int n = 0; n < 100 && busy !== 1'b0; n++)
    begin
      @(posedge clk);
      #1;
    end
    #1 chk({busy, act}, 2'b00);
    $display("test suspend done");
    close_out;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
endmodule : tb_top
